// ---- hdl/rss_sequencer.sv ----
// Reset source sequencer: combines reset sources, stretches the core reset,
// keeps cause flags and drives low-power side controls.
// Assumes all inputs synchronous to clock; analog sources are already digital.
//
// Overview of operation
// - Any reset returns I/O registers to defaults; core restarts from reset vector.
// - I/O ports forced to initial state at once when any source asserts.
// - After all sources clear, hold internal reset for selected delay period.
// - In power-off, charger detection issues a power-on reset pulse.
// - After power-on reset, stay in reset until delay expires, then run.
// - Reset pin low beyond minimum width resets even without clock.
// - Reset pin rising starts delay counter; release core after it elapses.
// - Enabled watchdog expiry gives internal reset of exactly one clock.
// - Delay starts on the watchdog pulse falling edge.
// - Droop detector enabled in every mode except power-off.
// - Enabled droop detector indication asserts reset immediately.
// - Droop indication clearing runs delay, then releases core.
// - Core held in reset while test-port reset bit is one.
// - Enabled watchdog stays active in every sleep mode but power-off.
// - Input buffers disabled when I/O and converter clocks both stop.
// - Wake-up input buffers stay enabled in deep sleep.
// - Input disable register bits switch off matching input buffers.
// - Debug fuse programmed keeps main clock running in sleep.
// - Discharge transistor off stops short-circuit detection.
// - One cause flag per source; power-on or zero write clears others.
// - In power-off only regulator and charger detection stay powered.
`timescale 1ns/10ps
module rss_sequencer
  import rss_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire rss_src_t src,
  input wire rss_mode_t sleep_mode,
  input wire logic [1:0] startup_time_select,
  input wire logic debug_enable_fuse,
  input wire logic [7:0] wake_pin_mask,
  input wire rss_bus_t bus,
  output logic [7:0] rdata,
  output logic core_reset,
  output logic io_reset,
  output logic fetch_vector,
  output logic supply_droop_detector_en,
  output logic watchdog_run,
  output logic [7:0] input_buf_en,
  output logic main_clock_keep,
  output logic short_detect_en,
  output logic logic_power_en
);

  function automatic logic [CNT_W-1:0] delay_cycles(input logic [1:0] sel);
    unique case (sel)
      2'b00: delay_cycles = CNT_W'(DELAY_CYC0);
      2'b01: delay_cycles = CNT_W'(DELAY_CYC1);
      2'b10: delay_cycles = CNT_W'(DELAY_CYC2);
      2'b11: delay_cycles = CNT_W'(DELAY_CYC3);
    endcase
  endfunction

  logic power_off;
  logic deep_sleep;
  logic por_pulse;
  logic wdog_pulse;
  logic raw_reset;
  logic [7:0] cause_q;
  logic [7:0] ctrl_q;
  logic [7:0] indis_q;
  logic wdog_pulse_q;
  logic [CNT_W-1:0] cnt_q;
  rss_state_t state_q;

  assign power_off = (sleep_mode == MODE_POWER_OFF);
  // Power-down and power-off stop both I/O and converter clocks
  assign deep_sleep = (sleep_mode == MODE_POWER_DOWN) || power_off;

  // Charger only counts while powered off; elsewhere the pack is live
  assign por_pulse = power_off && src.charger_seen;
  assign supply_droop_detector_en = !power_off;
  assign watchdog_run = ctrl_q[CTL_WDOG_EN] && !power_off;
  assign logic_power_en = !power_off;
  assign main_clock_keep = debug_enable_fuse;
  assign short_detect_en = ctrl_q[CTL_DFET_ON];

  // Wake-up pins keep their buffers; disabled pins off at all times
  assign input_buf_en = ~indis_q & (deep_sleep ? wake_pin_mask : 8'hFF);

  // Single-cycle watchdog reset, only when enabled
  assign wdog_pulse = src.wdog_expire && watchdog_run;

  // Combinational so ports reset in the same cycle, no clock edge needed
  assign raw_reset = por_pulse || !src.reset_pin_n || (supply_droop_detector_en && src.droop_low)
                     || wdog_pulse || src.testport_rst;
  assign io_reset = raw_reset || (state_q != ST_RUN);
  assign core_reset = io_reset;
  assign fetch_vector = (state_q == ST_STRETCH) && (cnt_q == '0);

  always_ff @(posedge clock) begin
    if (srst) begin
      wdog_pulse_q <= 1'b0;
    end else begin
      wdog_pulse_q <= wdog_pulse;
    end
  end

  // Delay starts when sources drop; watchdog drop is its pulse falling edge
  always_ff @(posedge clock) begin
    if (srst) begin
      state_q <= ST_HOLD;
      cnt_q <= '0;
    end else if (raw_reset) begin
      state_q <= ST_HOLD;
      cnt_q <= '0;
    end else begin
      unique case (state_q)
        ST_HOLD: begin
          state_q <= ST_STRETCH;
          cnt_q <= delay_cycles(startup_time_select) - CNT_W'(1);
        end
        ST_STRETCH: begin
          if (cnt_q == '0) begin
            state_q <= ST_RUN;
          end else begin
            cnt_q <= cnt_q - CNT_W'(1);
          end
        end
        ST_RUN: state_q <= ST_RUN;
      endcase
    end
  end

  // Cause flags: set wins over a software zero in the same cycle
  always_ff @(posedge clock) begin
    if (srst) begin
      cause_q <= CAUSE_RESET;
    end else begin
      if (bus.wr && bus.addr == ADDR_CAUSE) begin
        cause_q <= bus.wdata & 8'h1F;
      end
      if (por_pulse) begin
        cause_q[CF_TESTPORT:CF_EXTERNAL] <= 4'h0;
        cause_q[CF_POWERUP] <= 1'b1;
      end else begin
        if (!src.reset_pin_n) cause_q[CF_EXTERNAL] <= 1'b1;
        if (supply_droop_detector_en && src.droop_low) cause_q[CF_DROOP] <= 1'b1;
        if (wdog_pulse) cause_q[CF_WATCHDOG] <= 1'b1;
        if (src.testport_rst) cause_q[CF_TESTPORT] <= 1'b1;
      end
    end
  end

  // Control and input-disable registers return to defaults on any internal reset; cause flags keep their value
  always_ff @(posedge clock) begin
    if (srst || io_reset) begin
      ctrl_q <= CTRL_RESET;
      indis_q <= INDIS_RESET;
    end else if (bus.wr) begin
      if (bus.addr == ADDR_CTRL) ctrl_q <= bus.wdata & 8'h03;
      if (bus.addr == ADDR_INDIS) indis_q <= bus.wdata;
    end
  end

  // Read data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clock) begin
    if (srst) begin
      rdata <= 8'h00;
    end else if (bus.rd) begin
      unique case (bus.addr)
        ADDR_CAUSE: rdata <= cause_q;
        ADDR_CTRL: rdata <= ctrl_q;
        ADDR_INDIS: rdata <= indis_q;
        ADDR_STATUS: rdata <= {5'h00, wdog_pulse_q, state_q};
        default: rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

endmodule // rss_sequencer

// ---- hdl/rss_pkg.sv ----
// Constants and carrier types for the reset source sequencer.
// Assumes a single 100 MHz clock and a plain register port.
package rss_pkg;
  localparam int unsigned CLK_MHZ = 100;
  // Register offsets
  localparam logic [3:0] ADDR_CAUSE = 4'h0;
  localparam logic [3:0] ADDR_CTRL = 4'h1;
  localparam logic [3:0] ADDR_INDIS = 4'h2;
  localparam logic [3:0] ADDR_STATUS = 4'h3;
  // Cause flag bit positions
  localparam int unsigned CF_POWERUP = 0;
  localparam int unsigned CF_EXTERNAL = 1;
  localparam int unsigned CF_DROOP = 2;
  localparam int unsigned CF_WATCHDOG = 3;
  localparam int unsigned CF_TESTPORT = 4;
  // Control register fields
  localparam int unsigned CTL_WDOG_EN = 0;
  localparam int unsigned CTL_DFET_ON = 1;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] INDIS_RESET = 8'h00;
  localparam logic [7:0] CAUSE_RESET = 8'h00;
  // Release delay choices in microseconds, picked by startup_time_select
  localparam int unsigned DELAY_US0 = 4;
  localparam int unsigned DELAY_US1 = 16;
  localparam int unsigned DELAY_US2 = 64;
  localparam int unsigned DELAY_US3 = 256;
  localparam int unsigned DELAY_CYC0 = DELAY_US0 * CLK_MHZ;
  localparam int unsigned DELAY_CYC1 = DELAY_US1 * CLK_MHZ;
  localparam int unsigned DELAY_CYC2 = DELAY_US2 * CLK_MHZ;
  localparam int unsigned DELAY_CYC3 = DELAY_US3 * CLK_MHZ;
  localparam int unsigned CNT_W = 16;

  typedef enum logic [2:0] {
    MODE_ACTIVE = 3'b000,
    MODE_NOISE_RED = 3'b001,
    MODE_POWER_DOWN = 3'b010,
    MODE_POWER_SAVE = 3'b011,
    MODE_POWER_OFF = 3'b100
  } rss_mode_t;

  typedef enum logic [1:0] {
    ST_HOLD = 2'b00,
    ST_STRETCH = 2'b01,
    ST_RUN = 2'b10
  } rss_state_t;

  typedef struct packed {
    logic charger_seen;
    logic reset_pin_n;
    logic droop_low;
    logic wdog_expire;
    logic testport_rst;
  } rss_src_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } rss_bus_t;
endpackage

// ---- sim/rss_sequencer_assertions.sv ----
// Port checker for the reset source sequencer.
// Assumes a bind from the bench top and one clock with srst.
`timescale 1ns/10ps
module rss_seq_chk
  import rss_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire rss_src_t src,
  input wire rss_mode_t sleep_mode,
  input wire logic debug_enable_fuse,
  input wire logic [7:0] wake_pin_mask,
  input wire logic core_reset,
  input wire logic io_reset,
  input wire logic fetch_vector,
  input wire logic supply_droop_detector_en,
  input wire logic watchdog_run,
  input wire logic [7:0] input_buf_en,
  input wire logic main_clock_keep,
  input wire logic logic_power_en
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  wire off = sleep_mode == MODE_POWER_OFF;
  // Droop ignored and charger counted only in power-off
  wire raw = (src.droop_low & ~off) | ~src.reset_pin_n | src.testport_rst | (src.charger_seen & off)
             | (src.wdog_expire & watchdog_run);
  wire deep = (sleep_mode == MODE_POWER_DOWN) | off;
  sequence s_drop; $fell(raw); endsequence
  sequence s_wdog; src.wdog_expire && watchdog_run; endsequence
  AST_SRC: assert property (raw |-> core_reset) else $error("reset missing");
  AST_IO: assert property (io_reset == core_reset) else $error("io reset");
  AST_HOLD: assert property (s_drop |-> core_reset [*8]) else $error("early release");
  AST_WDOG: assert property (s_wdog |-> core_reset [*8]) else $error("watchdog");
  AST_FETCH: assert property (fetch_vector |-> core_reset ##1 (raw || !core_reset)) else $error("fetch");
  AST_DROOP: assert property (supply_droop_detector_en == !off) else $error("droop en");
  AST_WDOFF: assert property (off |-> !watchdog_run) else $error("wdog run");
  AST_BUF: assert property (deep |-> (input_buf_en & ~wake_pin_mask) == 8'h00) else $error("buf");
  AST_CLK: assert property (main_clock_keep == debug_enable_fuse) else $error("clock keep");
  AST_PWR: assert property (logic_power_en == !off) else $error("power");
endmodule // rss_seq_chk

// ---- sim/rss_src_model.sv ----
// Far-side reset sources: charger, pin, droop, watchdog, test port.
// Assumes one request bit per source, in cause flag order.
`timescale 1ns/10ps
module rss_src_model
  import rss_pkg::*;
(
  input wire logic clock,
  input wire logic [4:0] req,
  output rss_src_t src
);
  logic wd_q;
  initial wd_q = 1'b0;
  always @(posedge clock) wd_q <= req[3];
  // Watchdog gives one clock whatever the request length
  assign src = {req[0], ~req[1], req[2], req[3] & ~wd_q, req[4]};
endmodule // rss_src_model

// ---- sim/rss_sequencer_tb.sv ----
// Bench: random delays, sources taken in turn, register and sleep checks.
// Assumes the source model and a bound checker.
`timescale 1ns/10ps
module rss_sequencer_tb
  import rss_pkg::*;
;
  logic clock = 1'b0, srst = 1'b1, debug_enable_fuse = 1'b0;
  logic [4:0] req = 5'h00;
  rss_src_t src;
  rss_mode_t sleep_mode = MODE_ACTIVE;
  logic [1:0] startup_time_select = 2'd0;
  logic [7:0] wake_pin_mask = 8'h00, rdata, input_buf_en, d, m;
  rss_bus_t bus = '0;
  logic core_reset, io_reset, fetch_vector, supply_droop_detector_en;
  logic watchdog_run, main_clock_keep, short_detect_en, logic_power_en;
  int mismatches = 0, check_count = 0, seed = 95, c, k;
  rss_src_model PM (.clock(clock), .req(req), .src(src));
  rss_sequencer DUT (.*);
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (e !== g) begin
      mismatches++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clock) bus <= {a, v, 2'b10};
    @(posedge clock) bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clock) bus <= {a, 8'h00, 2'b01};
    @(posedge clock) bus.rd <= 1'b0;
    #1 chk("rdata", e, rdata);
  endtask
  // Bound covers the longest delay in use
  task automatic rel();
    c = 0;
    do begin
      @(posedge clock);
      #1 c++;
      // Longest select is 25600 cycles; a hang counts as a mismatch
      if (c > 30000) begin
        mismatches++;
        close_out();
      end
    end while (core_reset !== 1'b0);
  endtask
  function automatic int dly(input logic [1:0] s);
    int t[4] = '{DELAY_CYC0, DELAY_CYC1, DELAY_CYC2, DELAY_CYC3};
    return t[s];
  endfunction
  initial begin
    forever #5 clock = ~clock;
  end
  initial begin
    repeat (10) @(posedge clock);
    srst <= 1'b0;
    rel();
    rd(ADDR_CAUSE, 8'h00);
    for (int i = 0; i < 12; i++) begin
      k = 1 + i % 4;
      startup_time_select <= 2'($random(seed) & 1);
      if (k == 3) wr(ADDR_CTRL, 8'h01);
      @(posedge clock) req <= 5'(1 << k);
      if (k != 3) begin
        repeat (1 + ($random(seed) & 15)) @(posedge clock);
        req <= 5'h00;
        if (i >= 8) begin
          repeat (50) @(posedge clock);
          req <= 5'(1 << k);
          @(posedge clock) req <= 5'h00;
        end
      end
      rel();
      chk("release", 16'(dly(startup_time_select) + 1 + (k == 3)), 16'(c));
      req <= 5'h00;
      rd(ADDR_CAUSE, 8'(1 << k));
      if (i < 11) wr(ADDR_CAUSE, 8'h00);
    end
    sleep_mode <= MODE_POWER_OFF;
    startup_time_select <= 2'd3;
    @(posedge clock) req <= 5'h01;
    @(posedge clock) req <= 5'h00;
    sleep_mode <= MODE_ACTIVE;
    rel();
    chk("por_wait", 16'(dly(2'd3) + 1), 16'(c));
    rd(ADDR_CAUSE, 8'h01);
    rd(4'hF, 8'h00);
    wr(ADDR_CTRL, 8'h03);
    for (int j = 0; j < 5; j++) begin
      d = 8'($random(seed));
      m = 8'($random(seed));
      sleep_mode <= MODE_ACTIVE;
      wake_pin_mask <= m;
      debug_enable_fuse <= 1'(j);
      wr(ADDR_INDIS, d);
      rd(ADDR_INDIS, d);
      sleep_mode <= rss_mode_t'(j);
      @(posedge clock);
      #1 chk("inbuf", {8'h00, ~d & ((j == 2 || j == 4) ? m : 8'hFF)}, {8'h00, input_buf_en});
      chk("wdrun", 16'(j != 4), 16'(watchdog_run));
      chk("short", 16'h0001, 16'(short_detect_en));
    end
    sleep_mode <= MODE_ACTIVE;
    wr(ADDR_CTRL, 8'h00);
    #1 chk("short", 16'h0000, 16'(short_detect_en));
    @(posedge clock) req <= 5'h08;
    repeat (3) @(posedge clock);
    #1 chk("wd_off", 16'h0000, 16'(core_reset));
    close_out();
  end
endmodule // rss_sequencer_tb

bind rss_sequencer rss_seq_chk u_chk (
  .clock(clock),
  .srst(srst),
  .src(src),
  .sleep_mode(sleep_mode),
  .debug_enable_fuse(debug_enable_fuse),
  .wake_pin_mask(wake_pin_mask),
  .core_reset(core_reset),
  .io_reset(io_reset),
  .fetch_vector(fetch_vector),
  .supply_droop_detector_en(supply_droop_detector_en),
  .watchdog_run(watchdog_run),
  .input_buf_en(input_buf_en),
  .main_clock_keep(main_clock_keep),
  .logic_power_en(logic_power_en)
);
